// ---- rtl/dma_start_ctrl.sv ----
/*
 * Bus-master start sequencer: request, hold-off by the backend, abort on
 * lost grant, retry, and optional reuse of fetched data (recovery mode).
 * Assumes PCI pins sampled synchronously to ref_clk_i; active-low pins.
 */
// What this block does
// - while start-hold is asserted, keep the bus idle, no FRAMEN after grant.
// - grant lost during delayed start ends the cycle and pulses transfer end.
// - grant removed while framing waits on start-hold aborts the pending DMA cycle.
// - after abort, start the same cycle again when grant returns.
// - on restart, fetch the backend data again.
// - in FIFO recovery mode, reuse held data instead of refetching.
// - after abort, keep REQN asserted until FRAMEN is finally driven.
// - FRAMEN asserted at the first edge with GNTN low and start-hold low, once the burst is fetched.
module dma_start_ctrl
    import dma_start_pkg::*;
#(
    parameter int DATA_W     = DATA_W_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
    parameter int BURST_LEN  = FIFO_DEPTH_DEF
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              dma_go_i,
    input  wire logic              fifo_recovery_i,
    input  wire logic              start_hold_i,
    input  wire logic              gntn_i,
    input  wire logic              trdyn_i,
    input  wire logic              be_valid_i,
    output logic                   be_ready_o,
    input  wire logic [DATA_W-1:0] be_data_i,
    output logic                   reqn_o,
    output logic                   framen_o,
    output logic                   irdyn_o,
    output logic [DATA_W-1:0]      ad_o,
    output logic                   transfer_begin_strobe_o,
    output logic                   transfer_end_strobe_o,
    output logic                   busy_o
);
    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    // the whole burst is prefetched, so it must fit the fifo
    if (BURST_LEN < 1 || BURST_LEN > FIFO_DEPTH) begin
        $error("burst must fit the fifo");
    end

    localparam int CW = $clog2(FIFO_DEPTH + 1);
    localparam logic [CW-1:0] BURST_CNT = CW'(BURST_LEN);

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    master_state_t   state_reg;
    master_state_t   state_next;
    pci_master_out_t pin_reg;
    pci_master_out_t pin_next;
    backend_evt_t    evt_reg;
    backend_evt_t    evt_next;
    logic [CW-1:0]   fetched_reg;
    logic [CW-1:0]   fetched_next;
    logic [CW-1:0]   sent_reg;
    logic [CW-1:0]   sent_next;
    logic [DATA_W-1:0] ad_reg;
    logic            be_ready_reg;
    // registered so the pin carries no decode glitch
    logic            busy_reg;

    // ------------------------------------------------------------
    // data path
    // ------------------------------------------------------------
    wire             granted   = !gntn_i;
    wire             fifo_in_ready;
    wire             fifo_out_valid;
    wire [DATA_W-1:0] fifo_out_data;
    wire             fetching  = (state_reg == ST_FETCH) && (fetched_reg != BURST_CNT);
    wire             fetch_push = fetching && be_valid_i && fifo_in_ready;
    wire             data_phase = (state_reg == ST_DATA);
    wire             beat_done  = data_phase && !pin_reg.irdyn && !trdyn_i;
    wire             last_beat  = beat_done && (sent_reg + 1'b1 == BURST_CNT);
    // ad is the output stage: a word leaves the fifo when it goes on the bus
    wire             load_ad    = (state_reg == ST_FRAME) || (beat_done && !last_beat);
    wire             pop        = load_ad && fifo_out_valid;
    wire [DATA_W-1:0] ad_next   = load_ad ? fifo_out_data : ad_reg;
    wire             frame_go   = granted && !start_hold_i;
    // only a grant lost after it was seen aborts; waiting in REQ must not
    // flush, or the prefetched words would be lost before framing
    wire             abort_now  = (state_reg == ST_HOLD) && !granted;
    // without recovery the held words are dropped and refetched
    wire             flush      = abort_now && !fifo_recovery_i;

    dma_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .flush_i     (flush),
        .in_valid_i  (fetching && be_valid_i),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (be_data_i),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (pop),
        .out_data_o  (fifo_out_data)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next   = state_reg;
        pin_next     = '{reqn: 1'b1, framen: 1'b1, irdyn: 1'b1};
        evt_next     = '0;
        fetched_next = fetch_push ? fetched_reg + 1'b1 : fetched_reg;
        sent_next    = sent_reg;
        unique case (state_reg)
            ST_IDLE: begin
                fetched_next = '0;
                if (dma_go_i) begin
                    state_next         = ST_FETCH;
                    evt_next.begin_stb = 1'b1;
                end
            end
            ST_FETCH: begin
                // a refetch after an abort keeps the request up
                pin_next.reqn = pin_reg.reqn;
                if (fetched_next == BURST_CNT) begin
                    state_next   = ST_REQ;
                    pin_next.reqn = 1'b0;
                end
            end
            ST_REQ: begin
                pin_next.reqn = 1'b0;
                if (frame_go) begin
                    // grant and no hold at one edge: frame at once
                    state_next      = ST_FRAME;
                    pin_next.framen = 1'b0;
                    pin_next.reqn   = 1'b1;
                    sent_next       = '0;
                end else if (granted) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                pin_next.reqn = 1'b0;
                if (!granted) begin
                    // grant lost before framing: abort, then retry
                    evt_next.end_stb   = 1'b1;
                    evt_next.abort_stb = 1'b1;
                    if (fifo_recovery_i) begin
                        state_next = ST_REQ;
                    end else begin
                        state_next   = ST_FETCH;
                        fetched_next = '0;
                    end
                end else if (frame_go) begin
                    // first edge with hold low and grant present
                    state_next      = ST_FRAME;
                    pin_next.framen = 1'b0;
                    pin_next.reqn   = 1'b1;
                    sent_next       = '0;
                end
                // hold asserted: bus stays idle, no FRAMEN
            end
            ST_FRAME: begin
                state_next      = ST_DATA;
                pin_next.irdyn  = 1'b0;
                pin_next.framen = (BURST_CNT == CW'(1));
            end
            ST_DATA: begin
                pin_next.irdyn  = 1'b0;
                pin_next.framen = pin_reg.framen;
                if (beat_done) begin
                    sent_next = sent_reg + 1'b1;
                    if (sent_reg + 1'b1 == BURST_CNT - 1'b1) pin_next.framen = 1'b1;
                    if (sent_reg + 1'b1 == BURST_CNT) begin
                        state_next       = ST_IDLE;
                        pin_next         = '{reqn: 1'b1, framen: 1'b1, irdyn: 1'b1};
                        evt_next.end_stb = 1'b1;
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg    <= ST_IDLE;
            pin_reg      <= '{reqn: 1'b1, framen: 1'b1, irdyn: 1'b1};
            evt_reg      <= '0;
            fetched_reg  <= '0;
            sent_reg     <= '0;
            ad_reg       <= '0;
            be_ready_reg <= 1'b0;
            busy_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            pin_reg      <= pin_next;
            evt_reg      <= evt_next;
            fetched_reg  <= fetched_next;
            sent_reg     <= sent_next;
            ad_reg       <= ad_next;
            be_ready_reg <= (state_next == ST_FETCH) && (fetched_next != BURST_CNT);
            busy_reg     <= (state_next != ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reqn_o                  = pin_reg.reqn;
    assign framen_o                = pin_reg.framen;
    assign irdyn_o                 = pin_reg.irdyn;
    assign ad_o                    = ad_reg;
    assign transfer_begin_strobe_o = evt_reg.begin_stb;
    assign transfer_end_strobe_o   = evt_reg.end_stb;
    assign be_ready_o              = be_ready_reg;
    assign busy_o                  = busy_reg;
endmodule

// ---- pkg/dma_start_pkg.sv ----
/*
 * Shared constants and types for the bus-master start/stall/abort block.
 * Assumes a single PCI clock domain; PCI control pins are active low.
 */
package dma_start_pkg;
    // ------------------------------------------------------------
    // timing and default sizes
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          FRAME_LIMIT_CLK = 16;
    localparam int          DATA_W_DEF      = 32;
    localparam int          FIFO_DEPTH_DEF  = 4;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_REQ,
        ST_HOLD,
        ST_FRAME,
        ST_DATA
    } master_state_t;

    // pins driven toward the PCI bus
    typedef struct packed {
        logic reqn;
        logic framen;
        logic irdyn;
    } pci_master_out_t;

    // strobes toward the backend, except abort_stb, which reaches no output port
    typedef struct packed {
        logic begin_stb;
        logic end_stb;
        logic abort_stb;
    } backend_evt_t;
endpackage

// ---- rtl/dma_fifo.sv ----
/*
 * Small synchronous FIFO with valid/ready on both sides and a flush.
 * Assumes one clock and an active-low asynchronous reset.
 */
module dma_fifo
    import dma_start_pkg::*;
#(
    parameter int WIDTH = DATA_W_DEF,
    parameter int DEPTH = FIFO_DEPTH_DEF
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    // pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
        $error("depth must be a power of two >= 2");
    end

    localparam logic [AW:0] FULL_LEVEL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    wire              push  = in_valid_i && in_ready_o;
    wire              pop   = out_valid_o && out_ready_i;
    wire [AW:0]       level = wr_ptr_reg - rd_ptr_reg;

    assign in_ready_o  = (level != FULL_LEVEL) && !flush_i;
    assign out_valid_o = (level != '0);
    assign out_data_o  = mem_reg[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge ref_clk_i) begin
        if (push) mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else if (flush_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end
endmodule

// ---- bench/dma_start_ctrl_asserts.sv ----
/* port checker for the bus-master start sequencer.
   assumes a bind from the bench top; single clock domain. */
module dma_start_ctrl_asserts (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic fifo_recovery_i,
    input wire logic start_hold_i,
    input wire logic gntn_i,
    input wire logic reqn_o,
    input wire logic framen_o,
    input wire logic be_ready_o,
    input wire logic transfer_end_strobe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // ------------------------------------------------------------
    // start, hold and abort
    // ------------------------------------------------------------
    property p_hold_idle; start_hold_i && framen_o |=> framen_o; endproperty
    a_hold_idle: assert property (p_hold_idle) else $error("frame while held");
    property p_frame_go;
        !reqn_o && framen_o && !gntn_i && !start_hold_i && !be_ready_o |=> !framen_o;
    endproperty
    a_frame_go: assert property (p_frame_go) else $error("frame late");
    property p_abort_end;
        $rose(gntn_i) && framen_o && !reqn_o && !$past(reqn_o) && !$past(be_ready_o)
            |=> transfer_end_strobe_o;
    endproperty
    a_abort_end: assert property (p_abort_end) else $error("no end on lost grant");
    property p_req_kept; !reqn_o && framen_o |=> !reqn_o || !framen_o; endproperty
    a_req_kept: assert property (p_req_kept) else $error("request dropped");
    property p_frame_limit; $fell(gntn_i) && !reqn_o |-> ##[0:16] (!framen_o || gntn_i);
    endproperty
    a_frame_limit: assert property (p_frame_limit) else $error("frame over limit");
    // abort leaves reqn low, a normal end does not
    property p_refetch;
        !reqn_o && transfer_end_strobe_o && !fifo_recovery_i |-> ##[0:2] be_ready_o;
    endproperty
    a_refetch: assert property (p_refetch) else $error("no refetch");
    property p_reuse;
        !reqn_o && transfer_end_strobe_o && fifo_recovery_i |=> !be_ready_o [*4];
    endproperty
    a_reuse: assert property (p_reuse) else $error("refetch in recovery");
    property p_retry; !reqn_o && transfer_end_strobe_o |-> ##[1:80] !framen_o; endproperty
    a_retry: assert property (p_retry) else $error("no retry");
endmodule

// ---- bench/backend_arb_model.sv ----
/* arbiter, target and backend source standing beside the sequencer.
   assumes the bench opens and closes the grant through grant_en_i. */
module backend_arb_model (
    input wire logic  ref_clk_i,
    input wire logic  rst_n_i,
    input wire logic  grant_en_i,
    input wire logic  reqn_i,
    input wire logic  irdyn_i,
    input wire logic  be_ready_i,
    output logic        gntn_o,
    output logic        trdyn_o,
    output logic        be_valid_o,
    output logic [31:0] be_data_o,
    output int          taken_o
);
    timeunit 1ns;
    timeprecision 1ps;
    assign be_valid_o = 1'b1;
    // grant stays parked while enabled; target answers one cycle late
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gntn_o    <= 1'b1;
            trdyn_o   <= 1'b1;
            be_data_o <= 32'h0;
            taken_o   <= 0;
        end else begin
            gntn_o  <= !(grant_en_i && (!reqn_i || !gntn_o));
            trdyn_o <= irdyn_i;
            if (be_ready_i) begin
                be_data_o <= be_data_o + 32'h1;
                taken_o   <= taken_o + 1;
            end
        end
    end
endmodule

// ---- bench/test_pci_dma_start_stall_abort.sv ----
/* bench for the start sequencer: stall, grant loss, retry, recovery.
   assumes the checker is bound below; all waits are bounded. */
module test_pci_dma_start_stall_abort;
    timeunit 1ns;
    timeprecision 1ps;
    import dma_start_pkg::*;
    logic ref_clk_i = 0, rst_n_i = 0, dma_go_i = 0, fifo_recovery_i = 0;
    logic start_hold_i = 0, grant_en = 0;
    wire logic gntn, trdyn, be_valid, be_ready, reqn, framen, irdyn, bstb, estb, busy;
    wire logic [31:0] be_data, ad;
    int taken, fails = 0, tests_run = 0, n0;
    always #(CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;
    dma_start_ctrl dma_start_ctrl_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .dma_go_i(dma_go_i), .fifo_recovery_i(fifo_recovery_i), .start_hold_i(start_hold_i),
        .gntn_i(gntn), .trdyn_i(trdyn), .be_valid_i(be_valid), .be_ready_o(be_ready),
        .be_data_i(be_data), .reqn_o(reqn), .framen_o(framen), .irdyn_o(irdyn), .ad_o(ad),
        .transfer_begin_strobe_o(bstb), .transfer_end_strobe_o(estb), .busy_o(busy));
    backend_arb_model backend_arb_model_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .grant_en_i(grant_en), .reqn_i(reqn), .irdyn_i(irdyn), .be_ready_i(be_ready),
        .gntn_o(gntn), .trdyn_o(trdyn), .be_valid_o(be_valid), .be_data_o(be_data),
        .taken_o(taken));
    task final_report;
        $display("checks %0d bad %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %0h got %0h", n, e, g);
        end
    endtask
    function logic sig(input int s);
        case (s)
            0: sig = framen;
            1: sig = estb;
            2: sig = reqn;
            default: sig = busy;
        endcase
    endfunction
    task wt(input int s, input logic v);
        int n;
        n = 0;
        while (sig(s) !== v && n < 300) begin
            @(posedge ref_clk_i); #1;
            n++;
        end
        if (n >= 300) begin
            fails++;
            final_report;
        end
    endtask
    task start(input logic rec);
        @(posedge ref_clk_i);
        fifo_recovery_i <= rec;
        start_hold_i    <= 1'b1;
        grant_en        <= 1'b1;
        dma_go_i        <= 1'b1;
        @(posedge ref_clk_i);
        dma_go_i <= 1'b0;
        #1 chk("begin strobe", 32'h1, bstb);
    endtask
    task t_stall;
        start(1'b0);
        wt(2, 1'b0);
        repeat (3) @(posedge ref_clk_i);
        #1 chk("framen held", 32'h1, framen);
        @(posedge ref_clk_i);
        start_hold_i <= 1'b0;
        @(posedge ref_clk_i); #1;
        chk("framen on release", 32'h0, framen);
        @(posedge ref_clk_i);
        #1 chk("irdyn in data", 32'h0, irdyn);
        wt(3, 1'b0);
        chk("words fetched", 32'h4, taken);
        chk("last word", taken - 1, ad);
        grant_en <= 1'b0;
        $display("test stall done");
    endtask
    task t_abort(input logic rec);
        start(rec);
        wt(2, 1'b0);
        repeat (2) @(posedge ref_clk_i);
        grant_en <= 1'b0;
        wt(1, 1'b1);
        chk("reqn kept", 32'h0, reqn);
        n0 = taken;
        @(posedge ref_clk_i);
        grant_en <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        #1 chk("refetch count", rec ? n0 : n0 + 4, taken);
        @(posedge ref_clk_i);
        start_hold_i <= 1'b0;
        wt(0, 1'b0);
        wt(3, 1'b0);
        chk("last word", taken - 1, ad);
        grant_en <= 1'b0;
        $display("test abort done");
    endtask
    initial begin
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_stall;
        t_abort(1'b0);
        t_abort(1'b1);
        final_report;
    end
endmodule
bind dma_start_ctrl dma_start_ctrl_asserts dma_start_ctrl_asserts_inst (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .fifo_recovery_i(fifo_recovery_i),
    .start_hold_i(start_hold_i), .gntn_i(gntn_i), .reqn_o(reqn_o), .framen_o(framen_o),
    .be_ready_o(be_ready_o), .transfer_end_strobe_o(transfer_end_strobe_o));
